// ### include/single_access_ram_map_cfg.svh
/*
 * constants for the single-access ram decode and wait-state block:
 * block windows, sizes, mirror bases and the wait count.
 * assumes a 22-bit word address from every requester.
 */
`ifndef SINGLE_ACCESS_RAM_MAP_CFG_SVH
`define SINGLE_ACCESS_RAM_MAP_CFG_SVH
`define ADDR_W 22
`define DATA_W 16
`define BLK_AW 12
`define BLK_COUNT 8
`define DMA_CHANNELS 6
`define LOW_BASE 22'h00_8000
`define HIGH_BASE 22'h3F_8000
`define LOW_SPAN 22'h00_8000
`define HIGH_SPAN 22'h00_4000
`define STACK_LIMIT 22'h01_0000
`define PROG_WAITS 1
`endif

// ### include/single_access_ram_map_pkg.sv
/*
 * types shared by the single-access ram decode block.
 * assumes single_access_ram_map_cfg.svh is on the include path.
 */
`include "single_access_ram_map_cfg.svh"
package single_access_ram_map_pkg;
    // which of the three requesters an access comes from
    typedef enum logic [2:0] {
        SRC_DATA = 3'b001,
        SRC_PROG = 3'b010,
        SRC_DMA  = 3'b100
    } src_e;
    // one access request
    typedef struct packed {
        logic valid;
        logic write;
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
    } req_s;
    // answer to one requester
    typedef struct packed {
        logic ready;
        logic [`DATA_W-1:0] rdata;
    } rsp_s;
endpackage

// ### rtl/single_access_ram_block.sv
/*
 * one 4K x 16 single-access ram block, single port, read data one
 * cycle after the address. assumes the decoder grants one user a cycle.
 */
`timescale 1ns/1ns
`default_nettype none
module single_access_ram_block
    import single_access_ram_map_pkg::*;
(
    input wire logic clock,
    input wire logic en,
    input wire logic we,
    input wire logic [`BLK_AW-1:0] addr,
    input wire logic [`DATA_W-1:0] wdata,
    output logic [`DATA_W-1:0] rdata
);
    // storage capped at 4K words per block
    logic [`DATA_W-1:0] mem [0:(1<<`BLK_AW)-1];
    logic [`DATA_W-1:0] rdata_r;

    // synchronous read and write; no reset on storage
    always_ff @(posedge clock) begin
        if (en && we) begin
            mem[addr] <= wdata;
        end
        if (en) begin
            rdata_r <= mem[addr];
        end
    end
    assign rdata = rdata_r;
endmodule
`default_nettype wire

// ### rtl/single_access_ram_map.sv
/*
 * decode and wait-state logic for eight single-access ram blocks.
 * requesters: data bus, program bus and the dma engine (channel id
 * carried alongside). ready rises the cycle read data is valid.
 * assumes one request per requester held until ready, and that the
 * arbiter outside does not present colliding accesses to one block.
 */
`timescale 1ns/1ns
`default_nettype none
module single_access_ram_map
    import single_access_ram_map_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire req_s dataReq,
    input wire req_s progReq,
    input wire logic stackAccess,
    input wire req_s dmaReq,
    input wire logic [2:0] dmaChannel,
    output var rsp_s dataRsp,
    output var rsp_s progRsp,
    output var rsp_s dmaRsp,
    output logic secureHit_r
);
    ////////////////////////////////////////////////////////////////
    // reset release
    logic rstMeta_r, rstSync_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    ////////////////////////////////////////////////////////////////
    // address decode
    // block index from a 22-bit word address, 8 = miss
    function automatic logic [3:0] decode(input logic [`ADDR_W-1:0] a, input logic stk);
        logic [`ADDR_W-1:0] off;
        begin
            decode = 4'h8;
            off = '0;
            if (a >= `LOW_BASE && a < `LOW_BASE + `LOW_SPAN) begin
                off = a - `LOW_BASE;
                decode = {1'b0, off[14:12]};
            end else if (!stk && a >= `HIGH_BASE && a < `HIGH_BASE + `HIGH_SPAN) begin
                // block0-3 mirrors, old high block now four quarters
                off = a - `HIGH_BASE;
                decode = {2'b00, off[13:12]};
            end
            // stack never reaches the high mirror
        end
    endfunction

    logic [3:0] dataBlk, progBlk, dmaBlk;
    assign dataBlk = decode(dataReq.addr, stackAccess);
    assign progBlk = decode(progReq.addr, 1'b0);
    // dma reaches only block4-7, channels below DMA_CHANNELS (0-5) only
    assign dmaBlk = (decode(dmaReq.addr, 1'b0) >= 4'h4 && decode(dmaReq.addr, 1'b0) < 4'h8
                     && dmaChannel < 3'(`DMA_CHANNELS)) ? decode(dmaReq.addr, 1'b0) : 4'h8;

    ////////////////////////////////////////////////////////////////
    // wait-state and response state
    typedef enum logic [2:0] {
        P_IDLE = 3'b001,
        P_WAIT = 3'b010,
        P_DONE = 3'b100
    } pstate_e;
    pstate_e pState_r, pState_nxt;
    logic dataAck_r, dataAck_nxt, dmaAck_r, dmaAck_nxt;
    logic [3:0] dataSel_r, progSel_r, dmaSel_r;
    logic [3:0] dataSel_nxt, progSel_nxt, dmaSel_nxt;
    logic secure_nxt;
    logic progGo;
    logic progAck_r, progAck_nxt; // program ready, kept in its own flop

    // program bus issues to block4-7 only after its wait, to block0-3 at once
    always_comb begin
        pState_nxt = pState_r;
        progGo = 1'b0;
        progSel_nxt = progSel_r;
        case (pState_r)
            P_IDLE: begin
                if (progReq.valid && progBlk != 4'h8) begin
                    progSel_nxt = progBlk;
                    if (progBlk >= 4'h4) begin
                        pState_nxt = P_WAIT; // one wait
                    end else begin
                        progGo = 1'b1;
                        pState_nxt = P_DONE;
                    end
                end
            end
            P_WAIT: begin
                progGo = 1'b1;
                pState_nxt = P_DONE;
            end
            P_DONE: pState_nxt = P_IDLE;
            default: pState_nxt = P_IDLE;
        endcase
        // ready high for exactly the cycle spent in P_DONE
        progAck_nxt = (pState_nxt == P_DONE);
        // data and dma complete next cycle, no wait
        dataAck_nxt = dataReq.valid && dataBlk != 4'h8 && !dataAck_r;
        dmaAck_nxt = dmaReq.valid && dmaBlk != 4'h8 && !dmaAck_r;
        dataSel_nxt = dataBlk;
        dmaSel_nxt = dmaBlk;
        // blocks 2 and 3 and their mirrors are guarded
        secure_nxt = (dataReq.valid && (dataBlk == 4'h2 || dataBlk == 4'h3))
                  || (progReq.valid && (progBlk == 4'h2 || progBlk == 4'h3));
    end

    // register only
    always_ff @(posedge clock or negedge rstSync_r) begin
        if (!rstSync_r) begin
            pState_r <= P_IDLE;
            progAck_r <= 1'b0;
            dataAck_r <= 1'b0;
            dmaAck_r <= 1'b0;
            dataSel_r <= 4'h8;
            progSel_r <= 4'h8;
            dmaSel_r <= 4'h8;
            secureHit_r <= 1'b0;
        end else begin
            pState_r <= pState_nxt;
            progAck_r <= progAck_nxt;
            dataAck_r <= dataAck_nxt;
            dmaAck_r <= dmaAck_nxt;
            dataSel_r <= dataSel_nxt;
            progSel_r <= progSel_nxt;
            dmaSel_r <= dmaSel_nxt;
            secureHit_r <= secure_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // the eight blocks, 32K words here; total may reach 34K
    logic [`DATA_W-1:0] blkRdata [0:`BLK_COUNT-1];
    genvar g;
    generate
        for (g = 0; g < `BLK_COUNT; g++) begin : gBlk
            logic en, we;
            logic [`BLK_AW-1:0] ad;
            logic [`DATA_W-1:0] wd;
            // data bus wins, then dma, then program
            always_comb begin
                en = 1'b0;
                we = 1'b0;
                ad = '0;
                wd = '0;
                if (dataAck_nxt && dataBlk == 4'(g)) begin
                    en = 1'b1;
                    we = dataReq.write;
                    ad = dataReq.addr[`BLK_AW-1:0];
                    wd = dataReq.wdata;
                end else if (dmaAck_nxt && dmaBlk == 4'(g)) begin
                    en = 1'b1;
                    we = dmaReq.write;
                    ad = dmaReq.addr[`BLK_AW-1:0];
                    wd = dmaReq.wdata;
                end else if (progGo && progSel_nxt == 4'(g)) begin
                    en = 1'b1;
                    we = progReq.write;
                    ad = progReq.addr[`BLK_AW-1:0];
                    wd = progReq.wdata;
                end
            end
            single_access_ram_block uBlk (
                .clock(clock),
                .en(en),
                .we(we),
                .addr(ad),
                .wdata(wd),
                .rdata(blkRdata[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // answers
    assign dataRsp.ready = dataAck_r;
    assign dataRsp.rdata = dataSel_r < 4'h8 ? blkRdata[dataSel_r[2:0]] : '0;
    assign dmaRsp.ready = dmaAck_r;
    assign dmaRsp.rdata = dmaSel_r < 4'h8 ? blkRdata[dmaSel_r[2:0]] : '0;
    assign progRsp.ready = progAck_r;
    assign progRsp.rdata = progSel_r < 4'h8 ? blkRdata[progSel_r[2:0]] : '0;

    ////////////////////////////////////////////////////////////////
    // checks
    property p_dataNoWait;
        @(posedge clock) disable iff (!rstSync_r)
        (dataReq.valid && dataBlk >= 4'h4 && dataBlk < 4'h8 && !dataAck_r) |=> dataAck_r;
    endproperty
    a_dataNoWait: assert property (p_dataNoWait) else $error("data access waited");

    property p_progOneWait;
        @(posedge clock) disable iff (!rstSync_r)
        (pState_r == P_IDLE && progReq.valid && progBlk >= 4'h4 && progBlk < 4'h8)
            |=> !progRsp.ready ##1 progRsp.ready;
    endproperty
    a_progOneWait: assert property (p_progOneWait) else $error("program wait not one");

    property p_progLowFast;
        @(posedge clock) disable iff (!rstSync_r)
        (pState_r == P_IDLE && progReq.valid && progBlk < 4'h4) |=> progRsp.ready;
    endproperty
    a_progLowFast: assert property (p_progLowFast) else $error("low block waited");

    property p_stackLow;
        @(posedge clock) disable iff (!rstSync_r)
        (stackAccess && dataReq.addr >= `STACK_LIMIT) |-> dataBlk == 4'h8;
    endproperty
    a_stackLow: assert property (p_stackLow) else $error("stack hit high mirror");

    property p_dmaNoWait;
        @(posedge clock) disable iff (!rstSync_r)
        (dmaReq.valid && dmaBlk != 4'h8 && !dmaAck_r) |=> dmaAck_r;
    endproperty
    a_dmaNoWait: assert property (p_dmaNoWait) else $error("dma waited");

    property p_secure;
        @(posedge clock) disable iff (!rstSync_r)
        (dataReq.valid && (dataBlk == 4'h2 || dataBlk == 4'h3)) |=> secureHit_r;
    endproperty
    a_secure: assert property (p_secure) else $error("guarded block not flagged");

    property p_mirror;
        @(posedge clock) disable iff (!rstSync_r)
        (dataReq.addr >= `HIGH_BASE && dataReq.addr < `HIGH_BASE + `HIGH_SPAN && !stackAccess)
            |-> dataBlk == 4'(dataReq.addr[13:12]);
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror decode wrong");

    property p_readyPulse;
        @(posedge clock) disable iff (!rstSync_r)
        progRsp.ready |=> !progRsp.ready;
    endproperty
    a_readyPulse: assert property (p_readyPulse) else $error("program ready stuck");

    // a channel past the last one never gets an answer
    property p_dmaRefused;
        @(posedge clock) disable iff (!rstSync_r)
        (dmaReq.valid && dmaChannel >= 3'(`DMA_CHANNELS)) |=> !dmaRsp.ready;
    endproperty
    a_dmaRefused: assert property (p_dmaRefused) else $error("bad dma channel answered");
endmodule
`default_nettype wire

// ### sim/single_access_ram_requester.sv
/*
 * far-side model: one requester (data bus, program bus or dma) that
 * presents a request and waits a bounded time for the ready pulse.
 * assumes inputs change at the falling edge of clock.
 */
`timescale 1ns/1ns
`default_nettype none
module single_access_ram_requester
    import single_access_ram_map_pkg::*;
(
    input wire logic clock,
    input wire rsp_s rsp,
    output var req_s req
);
    // idle bus at start
    initial begin
        req = '0;
    end
    ////////////////////////////////////////////////////////////////
    // one access; lat counts falling edges to ready, 8 means silence
    task automatic access(input logic wr, input logic [`ADDR_W-1:0] a,
        input logic [`DATA_W-1:0] d, output int lat, output logic [`DATA_W-1:0] q);
        lat = 0;
        @(negedge clock);
        req.valid = 1'b1;
        req.write = wr;
        req.addr = a;
        req.wdata = d;
        // held until ready is seen or 8 falling edges pass
        while (lat < 8 && rsp.ready !== 1'b1) begin
            @(negedge clock);
            lat++;
        end
        q = rsp.rdata;
        // released lines show no stale value
        req.valid = 1'b0;
        req.addr = ~a;
        req.wdata = ~d;
        // idle gap so the ack can toggle
        @(negedge clock);
    endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
/*
 * self-checking bench for single_access_ram_map: three requester models, one
 * task per scenario. assumes the cfg header on the include path.
 */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import single_access_ram_map_pkg::*;
    logic clock;
    logic rst_n;
    logic stackAccess;
    logic [2:0] dmaChannel;
    req_s dataReq, progReq, dmaReq;
    rsp_s dataRsp, progRsp, dmaRsp;
    logic secureHit_r;
    int secureCycles = 0; // cycles seen with the security flag up
    int failures = 0;
    int n_compared = 0;
    int lat;
    logic [`DATA_W-1:0] q;
    single_access_ram_map u_dut (.clock(clock), .rst_n(rst_n), .dataReq(dataReq), .progReq(progReq),
        .stackAccess(stackAccess), .dmaReq(dmaReq), .dmaChannel(dmaChannel),
        .dataRsp(dataRsp), .progRsp(progRsp), .dmaRsp(dmaRsp), .secureHit_r(secureHit_r));
    single_access_ram_requester u_data (.clock(clock), .rsp(dataRsp), .req(dataReq));
    single_access_ram_requester u_prog (.clock(clock), .rsp(progRsp), .req(progReq));
    single_access_ram_requester u_dma (.clock(clock), .rsp(dmaRsp), .req(dmaReq));
    // 100 ns clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // catch any cycle with the security flag up
    always @(posedge clock) begin
        if (secureHit_r === 1'b1) begin
            secureCycles <= secureCycles + 1;
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // low write, high mirror read, block0-3
    task automatic t_mirror();
        for (int n = 0; n < 4; n++) begin
            u_data.access(1'b1, 22'h00_8000 + 22'(n * 4096), 16'hA500 + 16'(n), lat, q);
            u_data.access(1'b0, 22'h3F_8000 + 22'(n * 4096), 16'h0000, lat, q);
            check(q, 32'hA500 + n);
            check(lat, 1);
        end
    endtask
    // program bus waits once in block4-7, never in block0-3
    task automatic t_waits();
        u_data.access(1'b1, 22'h00_CFFF, 16'h1234, lat, q);
        u_data.access(1'b1, 22'h00_D000, 16'h5678, lat, q);
        check(lat, 1);
        u_prog.access(1'b0, 22'h00_CFFF, 16'h0000, lat, q);
        check(q, 32'h1234);
        check(lat, 2);
        u_prog.access(1'b0, 22'h00_D000, 16'h0000, lat, q);
        check(q, 32'h5678);
        check(lat, 2);
        u_prog.access(1'b0, 22'h00_8000, 16'h0000, lat, q);
        check(lat, 1);
        check(q, 32'hA500);
        // program-space write into block6 waits once as well
        u_prog.access(1'b1, 22'h00_E020, 16'hBEEF, lat, q);
        check(lat, 2);
        u_data.access(1'b0, 22'h00_E020, 16'h0000, lat, q);
        check(q, 32'hBEEF);
    endtask
    // every dma channel into block4-7; bad channel and low block refused
    task automatic t_dma();
        for (int ch = 0; ch < 8; ch++) begin
            dmaChannel = 3'(ch);
            u_dma.access(1'b1, 22'h00_C010 + 22'((ch % 4) * 4096), 16'hD000 + 16'(ch), lat, q);
            check(lat, ch < 6 ? 1 : 8);
            if (ch < 6) begin
                u_dma.access(1'b0, 22'h00_C010 + 22'((ch % 4) * 4096), 16'h0000, lat, q);
                check(q, 32'hD000 + ch);
            end
        end
        dmaChannel = 3'h0;
        u_dma.access(1'b0, 22'h00_8000, 16'h0000, lat, q);
        check(lat, 8);
    endtask
    // stack reaches low aliases only; unmapped stays silent
    task automatic t_stack();
        stackAccess = 1'b1;
        u_data.access(1'b0, 22'h3F_8000, 16'h0000, lat, q);
        check(lat, 8);
        u_data.access(1'b0, 22'h00_8000, 16'h0000, lat, q);
        check(q, 32'hA500);
        stackAccess = 1'b0;
        u_data.access(1'b0, 22'h00_7FFF, 16'h0000, lat, q);
        check(lat, 8);
    endtask
    // security flag only for block2/3
    task automatic t_secure();
        int secureBase;
        secureBase = secureCycles;
        u_data.access(1'b0, 22'h00_C000, 16'h0000, lat, q);
        check(secureCycles - secureBase, 0);
        u_data.access(1'b0, 22'h3F_A000, 16'h0000, lat, q);
        check(q, 32'hA502);
        @(negedge clock);
        check(secureCycles - secureBase, 1);
        // code fetched from the upper mirror is guarded too
        u_prog.access(1'b0, 22'h3F_B000, 16'h0000, lat, q);
        check(q, 32'hA503);
        check(lat, 1);
        @(negedge clock);
        check(secureCycles - secureBase, 2);
    endtask
    ////////////////////////////////////////////////////////////////
    // hang guard, well above the whole sequence
    initial begin
        repeat (5000) @(posedge clock);
        failures++;
        wrap_up();
    end
    // main sequence
    initial begin
        rst_n = 1'b0;
        stackAccess = 1'b0;
        dmaChannel = 3'h0;
        repeat (3) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        // two-flop release needs edges before the first request
        repeat (3) @(posedge clock);
        t_mirror();
        t_waits();
        t_dma();
        t_stack();
        t_secure();
        wrap_up();
    end
endmodule
`default_nettype wire
